// ---- rtl/ebu_top.sv ----
// External bus unit: window decode, bus cycle sequencer, arbitration
module ebu_top
  import ebu_pkg::*;
(
  // Clock and reset
  input  logic                     core_clk,
  input  logic                     rst,
  // Request side
  input  logic                     req_valid,
  output logic                     req_ready,
  input  ebu_req_t                 req,
  // Response side
  output logic                     rsp_valid,
  input  logic                     rsp_ready,
  output ebu_rsp_t                 rsp,
  // Configuration
  input  logic                     ext_bus_en,
  input  logic [LINES_W-1:0]       addr_lines,
  input  logic [SEG_W-1:0]         seg_lines,
  input  logic                     cs_gen_en,
  input  logic                     ready_act_high,
  input  logic                     ready_async,
  input  logic                     arb_en,
  input  logic                     slave_mode,
  input  ebu_tcon_t [NCS-1:0]      cs_timing_config,
  input  ebu_fcon_t [NCS-1:0]      cs_function_config,
  input  ebu_wsel_t [NWIN-1:0]     window_select_config,
  // Status
  output logic                     bus_busy,
  // External bus pins
  output logic                     bus_reference_clock,
  output logic [ADDR_W-1:0]        addr_out,
  output logic [ADDR_W-1:0]        addr_oe,
  output logic [DATA_W-1:0]        ad_out,
  output logic [DATA_W-1:0]        ad_oe,
  input  logic [DATA_W-1:0]        ad_in,
  output logic                     ale,
  output logic                     rd_n,
  output logic                     wr_n,
  output logic [NCS-1:0]           cs_n,
  output logic                     ctl_oe,
  input  logic                     ready_pin,
  // Arbitration pins
  input  logic                     hold_req_n_in,
  output logic                     bus_request_out_n,
  input  logic                     hold_acknowledge_n_in,
  output logic                     hold_acknowledge_n_out,
  output logic                     hold_acknowledge_oe,
  // Local peripheral bus
  output logic                     lpb_sel,
  output logic                     lpb_wr,
  output logic [ADDR_W-1:0]        lpb_addr,
  output logic [DATA_W-1:0]        lpb_wdata,
  input  logic [DATA_W-1:0]        lpb_rdata,
  input  logic                     lpb_ready
);

  typedef struct packed {
    ebu_state_t        st;
    logic [DIV_W-1:0]  div;
    logic              refclk;
    logic [CNT_W-1:0]  cnt;
    logic [WIN_W-1:0]  win;
    ebu_req_t          cur;
    logic              rdy_d;
    logic              req_rdy;
    logic              push;
    ebu_rsp_t          rsp;
    logic [ADDR_W-1:0] aout;
    logic [ADDR_W-1:0] aoe;
    logic [DATA_W-1:0] adout;
    logic [DATA_W-1:0] adoe;
    logic              ale;
    logic              rd_n;
    logic              wr_n;
    logic [NCS-1:0]    cs_n;
    logic              ctl_oe;
    logic              bus_req_n;
    logic              hold_ack_n;
    logic              hold_ack_oe;
    logic              lpb_sel;
    logic              busy;
  } ebu_top_st_t;

  localparam ebu_top_st_t RST_ST = '{
    st: ST_IDLE, rd_n: 1'b1, wr_n: 1'b1, cs_n: '1, bus_req_n: 1'b1,
    hold_ack_n: 1'b1, hold_ack_oe: 1'b1, default: '0};

  ebu_top_st_t       s;
  ebu_top_st_t       s_nxt;
  logic [SYNC_W-1:0] pins_s;
  logic              ready_s;
  logic              hold_s;
  logic              hold_ack_s;
  logic [DATA_W-1:0] ad_s;
  logic [NWIN-1:0]   win_hit;
  logic [WIN_W-1:0]  win_sel;
  logic [ADDR_W-1:0] line_en;
  logic              buf_in_ready;
  ebu_tcon_t         tcon;
  ebu_fcon_t         fcon;
  logic              rise;
  logic              rdy_raw;
  logic              rdy_ok;
  logic              master_arb;
  logic              slave_arb;
  logic              granted;
  logic [DATA_W-1:0] dmask;

  ebu_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({ready_pin, hold_req_n_in, hold_acknowledge_n_in, ad_in}),
    .q        (pins_s)
  );

  assign {ready_s, hold_s, hold_ack_s, ad_s} = pins_s;

  // Window hit on the upper address bits, before the cycle starts
  genvar g;
  generate
    for (g = 0; g < NWIN; g++)
    begin : g_win
      logic [WBASE_W-1:0] wmask;
      assign wmask = {WBASE_W{1'b1}} << window_select_config[g].size;
      assign win_hit[g] = cs_function_config[g+1].en &&
        (((req.addr[ADDR_W-1:WBASE_LSB] ^ window_select_config[g].base)
          & wmask) == '0);
    end
    // Lines beyond the programmed count stay released for port use
    for (g = 0; g < ADDR_W; g++)
    begin : g_line
      if (g < LOW_W)
      begin : g_lo
        assign line_en[g] = (LINES_W'(g) < addr_lines);
      end
      else
      begin : g_hi
        assign line_en[g] = (LINES_W'(g) < addr_lines) &&
          (SEG_W'(g - LOW_W) < seg_lines);
      end
    end
  endgenerate

  // Higher window index wins; no hit leaves the default set
  always_comb
  begin
    win_sel = WIN_DEFAULT;
    for (int k = 0; k < NWIN; k++)
    begin
      if (win_hit[k])
      begin
        win_sel = WIN_W'(k + 1);
      end
    end
  end

  // Configuration follows the window of the running cycle
  assign tcon  = cs_timing_config[s.win];
  assign fcon  = cs_function_config[s.win];
  assign dmask = fcon.bus16 ? DMASK16 : DMASK8;

  always_comb
  begin
    s_nxt      = s;
    s_nxt.push = 1'b0;
    rise       = 1'b0;
    // Reference clock divider; bus cycle pin changes land on its rising edge
    if (s.div == DIV_LAST)
    begin
      s_nxt.div    = '0;
      s_nxt.refclk = ~s.refclk;
      rise         = ~s.refclk;
    end
    else
    begin
      s_nxt.div = s.div + 1'b1;
    end
    rdy_raw     = (ready_s == ready_act_high);
    s_nxt.rdy_d = rdy_raw;
    rdy_ok      = ready_async ? s.rdy_d : rdy_raw;
    master_arb  = arb_en & ~slave_mode;
    slave_arb   = arb_en & slave_mode;
    granted     = ~slave_arb | ~hold_ack_s;
    s_nxt.hold_ack_oe = ~slave_arb;
    s_nxt.bus_req_n   = 1'b1;
    case (s.st)
      ST_IDLE:
      begin
        s_nxt.ctl_oe = ext_bus_en & ~slave_arb;
        // An offered slot wins over a hold, so no accepted request is lost
        if (req_valid && s.req_rdy)
        begin
          s_nxt.cur = req;
          s_nxt.win = win_sel;
          if (req.to_lpb)
          begin
            s_nxt.st      = ST_LPB;
            s_nxt.lpb_sel = 1'b1;
          end
          else if (!ext_bus_en)
          begin
            s_nxt.push = 1'b1;
            s_nxt.rsp  = '{rdata: '0, err: 1'b1};
          end
          else
          begin
            s_nxt.st = ST_START;
          end
        end
        else if (master_arb && !hold_s)
        begin
          s_nxt.st         = ST_HELD;
          s_nxt.ctl_oe     = 1'b0;
          s_nxt.hold_ack_n = 1'b0;
        end
      end
      ST_HELD:
      begin
        s_nxt.bus_req_n = ~(req_valid & ~req.to_lpb);
        if (hold_s)
        begin
          s_nxt.st         = ST_IDLE;
          s_nxt.hold_ack_n = 1'b1;
          s_nxt.ctl_oe     = ext_bus_en;
        end
      end
      ST_LPB:
      begin
        if (lpb_ready)
        begin
          s_nxt.lpb_sel = 1'b0;
          s_nxt.push    = 1'b1;
          s_nxt.rsp     = '{rdata: lpb_rdata, err: 1'b0};
          s_nxt.st      = ST_IDLE;
        end
      end
      ST_START:
      begin
        s_nxt.bus_req_n = granted;
        if (rise && granted)
        begin
          s_nxt.st     = ST_ADDR;
          s_nxt.cnt    = CNT_W'(tcon.addr_ph);
          s_nxt.ctl_oe = 1'b1;
          s_nxt.ale    = 1'b1;
          s_nxt.aout   = s.cur.addr;
          s_nxt.cs_n   = cs_gen_en ? ~(CS_ONE << s.win) : '1;
          if (fcon.mux)
          begin
            s_nxt.aoe   = line_en & ~LOW_MASK;
            s_nxt.adout = s.cur.addr[DATA_W-1:0];
            s_nxt.adoe  = line_en[DATA_W-1:0];
          end
          else
          begin
            s_nxt.aoe   = line_en;
            s_nxt.adout = s.cur.wdata;
            s_nxt.adoe  = s.cur.write ? dmask : '0;
          end
        end
      end
      ST_ADDR:
      begin
        if (rise)
        begin
          if (s.cnt != '0)
          begin
            s_nxt.cnt = s.cnt - 1'b1;
          end
          else
          begin
            s_nxt.st    = ST_CMD;
            s_nxt.cnt   = tcon.cmd_wait;
            s_nxt.ale   = 1'b0;
            s_nxt.rd_n  = s.cur.write;
            s_nxt.wr_n  = ~s.cur.write;
            s_nxt.adout = s.cur.wdata;
            s_nxt.adoe  = s.cur.write ? dmask : '0;
          end
        end
      end
      ST_CMD:
      begin
        if (rise)
        begin
          if (s.cnt != '0)
          begin
            s_nxt.cnt = s.cnt - 1'b1;
          end
          else if (!(fcon.rdy_en && !rdy_ok))
          begin
            s_nxt.st   = ST_RECOV;
            s_nxt.cnt  = CNT_W'(tcon.recov);
            s_nxt.rd_n = 1'b1;
            s_nxt.wr_n = 1'b1;
            s_nxt.push = 1'b1;
            s_nxt.rsp  = '{rdata: ad_s & dmask, err: 1'b0};
          end
        end
      end
      ST_RECOV:
      begin
        if (rise)
        begin
          if (s.cnt != '0)
          begin
            s_nxt.cnt = s.cnt - 1'b1;
          end
          else
          begin
            s_nxt.st     = ST_IDLE;
            s_nxt.cs_n   = '1;
            s_nxt.aoe    = '0;
            s_nxt.adoe   = '0;
            s_nxt.ctl_oe = ~slave_arb;
          end
        end
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // A slot in the response buffer is reserved before a request is taken
    s_nxt.req_rdy = (s_nxt.st == ST_IDLE) && buf_in_ready &&
                    !s_nxt.push && !s.push;
    s_nxt.busy    = (s_nxt.st != ST_IDLE) && (s_nxt.st != ST_HELD);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= RST_ST;
    end
    else
    begin
      s <= s_nxt;
    end
  end

  ebu_buf #(
    .W     ($bits(ebu_rsp_t)),
    .DEPTH (RSP_DEPTH)
  ) u_rsp_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (s.push),
    .in_ready  (buf_in_ready),
    .in_data   (s.rsp),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp)
  );

  assign req_ready              = s.req_rdy;
  assign bus_busy               = s.busy;
  assign bus_reference_clock    = s.refclk;
  assign addr_out               = s.aout;
  assign addr_oe                = s.aoe;
  assign ad_out                 = s.adout;
  assign ad_oe                  = s.adoe;
  assign ale                    = s.ale;
  assign rd_n                   = s.rd_n;
  assign wr_n                   = s.wr_n;
  assign cs_n                   = s.cs_n;
  assign ctl_oe                 = s.ctl_oe;
  assign bus_request_out_n      = s.bus_req_n;
  assign hold_acknowledge_n_out = s.hold_ack_n;
  assign hold_acknowledge_oe    = s.hold_ack_oe;
  assign lpb_sel                = s.lpb_sel;
  assign lpb_wr                 = s.cur.write;
  assign lpb_addr               = s.cur.addr;
  assign lpb_wdata              = s.cur.wdata;

endmodule // ebu_top

// ---- common/ebu_pkg.sv ----
// Shared constants and carrier types for the external bus unit
package ebu_pkg;

  // Clocking: core clock and bus reference clock periods
  localparam int CLK_PERIOD_NS = 50;
  localparam int REF_PERIOD_NS = 400;
  localparam int REF_HALF_CYC  = REF_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W         = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_HALF_CYC - 1);

  // Bus geometry
  localparam int ADDR_W    = 24;
  localparam int DATA_W    = 16;
  localparam int LOW_W     = 16;
  localparam int NWIN      = 4;
  localparam int NCS       = NWIN + 1;
  localparam int WIN_W     = 3;
  localparam int WBASE_LSB = 12;
  localparam int WBASE_W   = ADDR_W - WBASE_LSB;
  localparam int LINES_W   = 5;
  localparam int SEG_W     = 3;
  localparam int CNT_W     = 4;
  localparam int RSP_DEPTH = 2;

  // Fixed patterns
  localparam logic [DATA_W-1:0] DMASK16 = 16'hFFFF;
  localparam logic [DATA_W-1:0] DMASK8  = 16'h00FF;
  localparam logic [ADDR_W-1:0] LOW_MASK = 24'h00FFFF;
  localparam logic [NCS-1:0]    CS_ONE  = 5'h01;
  localparam logic [WIN_W-1:0]  WIN_DEFAULT = 3'h0;

  // Synchroniser lanes: ready, hold request, hold acknowledge, AD bus
  localparam int SYNC_W = DATA_W + 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'h3, 16'h0000};

  // Per chip-select timing set, counted in reference clock periods
  typedef struct packed {
    logic [1:0]       addr_ph;
    logic [CNT_W-1:0] cmd_wait;
    logic [1:0]       recov;
  } ebu_tcon_t;

  // Per chip-select function set
  typedef struct packed {
    logic en;
    logic bus16;
    logic mux;
    logic rdy_en;
  } ebu_fcon_t;

  // Address window: base of the upper address bits, size as 4 KB << size
  typedef struct packed {
    logic [WBASE_W-1:0] base;
    logic [3:0]         size;
  } ebu_wsel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic              to_lpb;
  } ebu_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              err;
  } ebu_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HELD, ST_LPB, ST_START, ST_ADDR, ST_CMD, ST_RECOV
  } ebu_state_t;

endpackage

// ---- rtl/ebu_sync.sv ----
// Two-stage synchroniser for pins arriving from outside the core clock
module ebu_sync
  import ebu_pkg::*;
#(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
)(
  // Clock and reset
  input  logic         core_clk,
  input  logic         rst,
  // Data
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ebu_sync_st_t;

  ebu_sync_st_t s;
  ebu_sync_st_t s_nxt;

  always_comb
  begin
    s_nxt.s1 = d;
    s_nxt.s2 = s.s1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '{s1: RST, s2: RST};
    end
    else
    begin
      s <= s_nxt;
    end
  end

  assign q = s.s2;

endmodule // ebu_sync

// ---- rtl/ebu_buf.sv ----
// Small valid/ready buffer; the head entry always sits in slot 0
module ebu_buf
  import ebu_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 2
)(
  // Clock and reset
  input  logic         core_clk,
  input  logic         rst,
  // Fill side
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  // Drain side
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
    logic                    vld;
  } ebu_buf_st_t;

  ebu_buf_st_t s;
  ebu_buf_st_t s_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (s.cnt != FULL);
  assign out_valid = s.vld;
  assign out_data  = s.mem[0];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Shifting keeps the output straight off a register, at the cost of
  // moving every entry on a pop; cheap at this depth
  always_comb
  begin
    s_nxt = s;
    if (pop)
    begin
      for (int k = 0; k < DEPTH - 1; k++)
      begin
        s_nxt.mem[k] = s.mem[k+1];
      end
      s_nxt.cnt = s.cnt - 1'b1;
    end
    if (push)
    begin
      s_nxt.mem[s_nxt.cnt] = in_data;
      s_nxt.cnt = s_nxt.cnt + 1'b1;
    end
    // Own flop for valid so the drain side sees no decode logic
    s_nxt.vld = (s_nxt.cnt != '0);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= s_nxt;
    end
  end

endmodule // ebu_buf

// ---- test/ebu_monitor.sv ----
// Port-level checker for the external bus unit
module ebu_monitor
  import ebu_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // Request and response
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              rsp_ready,
  input wire ebu_rsp_t          rsp,
  // Configuration and status
  input wire logic              ext_bus_en,
  input wire logic              arb_en,
  input wire logic              slave_mode,
  input wire logic              bus_busy,
  // Bus pins
  input wire logic              bus_reference_clock,
  input wire logic [ADDR_W-1:0] addr_oe,
  input wire logic [DATA_W-1:0] ad_oe,
  input wire logic              ale,
  input wire logic              rd_n,
  input wire logic              wr_n,
  input wire logic [NCS-1:0]    cs_n,
  input wire logic              ctl_oe,
  input wire logic              bus_request_out_n,
  input wire logic              hold_acknowledge_n_out,
  input wire logic              hold_acknowledge_oe,
  // Local peripheral bus
  input wire logic              lpb_sel,
  input wire logic              lpb_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  reset_state_a: assert property (
    $fell(rst) |-> cs_n == 5'h1F && hold_acknowledge_oe && !rsp_valid)
    else $error("outputs not at reset values");
  ref_period_a: assert property (
    $rose(bus_reference_clock) |-> bus_reference_clock[*4]
      ##1 !bus_reference_clock[*4] ##1 bus_reference_clock)
    else $error("reference clock not 4 high 4 low");
  pins_on_rise_a: assert property (
    $changed({ale, rd_n, wr_n, cs_n}) |-> $rose(bus_reference_clock))
    else $error("bus control moved off a reference rise");
  cmd_after_addr_a: assert property (
    $fell(rd_n) || $fell(wr_n) |-> $fell(ale))
    else $error("command did not end the address phase");
  read_released_a: assert property (
    !rd_n |-> ad_oe == 16'h0000)
    else $error("data lines driven during read command");
  single_chip_a: assert property (
    !ext_bus_en && !bus_busy |=> cs_n == 5'h1F && !ale)
    else $error("external activity in single-chip mode");
  hold_float_a: assert property (
    arb_en && !slave_mode && !hold_acknowledge_n_out
      |-> !ctl_oe && addr_oe == 24'h000000 && ad_oe == 16'h0000)
    else $error("bus driven while held");
  slave_ack_in_a: assert property (
    (arb_en && slave_mode)[*2] |-> !hold_acknowledge_oe)
    else $error("acknowledge driven in slave mode");
  arb_off_a: assert property (
    !arb_en && !$past(arb_en) |-> bus_request_out_n && hold_acknowledge_n_out)
    else $error("arbitration lines active while disabled");
  cs_onehot_a: assert property (
    cs_n != 5'h1F |-> $onehot(~cs_n))
    else $error("more than one chip select active");
  lpb_answer_a: assert property (
    lpb_sel && lpb_ready |=> !lpb_sel ##1 rsp_valid)
    else $error("peripheral access not answered in time");
  rsp_hold_a: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("response changed before it was taken");
endmodule // ebu_monitor

bind ebu_top ebu_monitor u_monitor (.*);

// ---- test/ebu_ext_mem.sv ----
// Behavioural external memory with a ready output for the bus unit
module ebu_ext_mem
  import ebu_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Pins from the unit
  input  wire logic              bus_reference_clock,
  input  wire logic [ADDR_W-1:0] addr_out,
  input  wire logic [DATA_W-1:0] ad_out,
  input  wire logic [DATA_W-1:0] ad_oe,
  input  wire logic              ale,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic              ctl_oe,
  input  wire logic              ready_act_high,
  // Pins back to the unit and last written word
  output logic [DATA_W-1:0]      ad_in,
  output logic                   ready_pin,
  output logic [DATA_W-1:0]      last_wr
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [DATA_W-1:0] adr_lo;
  logic              ref_q;
  logic              cmd;

  assign cmd = ctl_oe && !(rd_n && wr_n);

  initial
  begin
    ad_in = '0;
    ready_pin = 1'b0;
    last_wr = '0;
    ref_q = 1'b0;
    adr_lo = '0;
  end

  always @(posedge core_clk)
  begin
    ref_q <= bus_reference_clock;
    // Driven AD bits carry the address when multiplexed
    if (ctl_oe && ale)
      adr_lo <= (ad_out & ad_oe) | (addr_out[15:0] & ~ad_oe);
    if (ctl_oe && !rd_n)
      ad_in <= adr_lo ^ 16'h5A3C;
    else
      ad_in <= ~ad_in; // Released lines never hold a stale word
    if (ctl_oe && !wr_n)
      last_wr <= ad_out & ad_oe;
    // Moves at reference falls only, so it is settled at every rise
    if (ref_q && !bus_reference_clock)
      ready_pin <= (cmd == ready_act_high);
  end
endmodule // ebu_ext_mem

// ---- test/ebu_top_tb.sv ----
// Self-checking bench for the external bus unit
module ebu_top_tb
  import ebu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic              lpb;
    logic [DATA_W-1:0] exp;
    logic [NCS-1:0]    cs;
  } ebu_row_t;

  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 req_valid = 1'b0;
  logic                 rsp_ready = 1'b0;
  ebu_req_t             req = '0;
  logic                 ext_bus_en = 1'b1;
  logic [LINES_W-1:0]   addr_lines = 5'h18;
  logic [SEG_W-1:0]     seg_lines = 3'h7;
  logic                 cs_gen_en = 1'b1;
  logic                 ready_act_high = 1'b1;
  logic                 ready_async = 1'b0;
  logic                 arb_en = 1'b0;
  logic                 slave_mode = 1'b0;
  logic                 hold_req_n_in = 1'b1;
  logic                 hold_acknowledge_n_in = 1'b1;
  logic [DATA_W-1:0]    lpb_rdata = '0;
  logic                 lpb_ready = 1'b0;
  ebu_tcon_t [NCS-1:0]  cs_timing_config = '0;
  ebu_fcon_t [NCS-1:0]  cs_function_config = {4'h8, 4'hF, 4'hC, 4'hA, 4'hC};
  ebu_wsel_t [NWIN-1:0] window_select_config =
    {16'h2000, 16'h2004, 16'h1000, 16'h1004};
  logic                 req_ready, rsp_valid, bus_busy, bus_reference_clock;
  logic                 ale, rd_n, wr_n, ctl_oe, ready_pin, lpb_sel, lpb_wr;
  logic                 bus_request_out_n, hold_acknowledge_n_out;
  logic                 hold_acknowledge_oe;
  ebu_rsp_t             rsp;
  logic [ADDR_W-1:0]    addr_out, addr_oe, lpb_addr, aoe_seen;
  logic [7:0]           rd_len;
  logic [DATA_W-1:0]    ad_out, ad_oe, ad_in, lpb_wdata, last_wr;
  logic [NCS-1:0]       cs_n, cs_seen;
  ebu_row_t             rows [8];
  int                   failures = 0;
  int                   comparisons = 0;

  ebu_top DUT (.*);
  ebu_ext_mem u_mem (.*);

  always #25 core_clk = ~core_clk;

  // Peripheral answers one cycle after select
  always @(posedge core_clk)
  begin
    lpb_ready <= lpb_sel && !lpb_ready;
    lpb_rdata <= lpb_addr[15:0] ^ 16'h1234;
    cs_seen <= (req_valid && req_ready) ? 5'h00 : (cs_seen | ~cs_n);
    aoe_seen <= ale ? addr_oe : aoe_seen;
    rd_len <= (req_valid && req_ready) ? 8'h00 : rd_len + 8'(!rd_n);
  end

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic do_req(ebu_req_t r, output ebu_rsp_t s);
    int n;
    @(posedge core_clk);
    req <= r;
    req_valid <= 1'b1;
    for (n = 0; n < 400 && !req_ready; n++)
      @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (n = 0; n < 400 && !rsp_valid; n++)
      @(negedge core_clk);
    chk("rsp_valid", rsp_valid, 1'b1);
    s = rsp;
    @(posedge core_clk);
    rsp_ready <= 1'b1;
    @(posedge core_clk);
    rsp_ready <= 1'b0;
  endtask

  task automatic run_row(ebu_row_t w);
    ebu_rsp_t s;
    do_req('{w.addr, w.wdata, w.write, w.lpb}, s);
    chk("err", s.err, 1'b0);
    chk("data", w.write ? last_wr : s.rdata, w.exp);
    chk("cs", cs_seen, w.cs);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    finish_test();
  end

  initial
  begin
    ebu_rsp_t s;
    int p;
    int k;
    // Windows 2 and 4 sit inside 1 and 3 and must win the overlap
    rows[0] = '{24'h100010, 16'h0000, 1'b0, 1'b0, 16'h5A2C, 5'h04};
    rows[1] = '{24'h101020, 16'h0000, 1'b0, 1'b0, 16'h001C, 5'h02};
    rows[2] = '{24'h200040, 16'h0000, 1'b0, 1'b0, 16'h007C, 5'h10};
    rows[3] = '{24'h203080, 16'h0000, 1'b0, 1'b0, 16'h6ABC, 5'h08};
    rows[4] = '{24'h300000, 16'h0000, 1'b0, 1'b0, 16'h5A3C, 5'h01};
    rows[5] = '{24'h000400, 16'h0000, 1'b0, 1'b1, 16'h1634, 5'h00};
    rows[6] = '{24'h100022, 16'hBEEF, 1'b1, 1'b0, 16'hBEEF, 5'h04};
    rows[7] = '{24'h101022, 16'hBEEF, 1'b1, 1'b0, 16'h00EF, 5'h02};
    repeat (15) @(posedge core_clk);
    @(negedge core_clk);
    chk("ack_oe", hold_acknowledge_oe, 1'b1);
    chk("cs_n", cs_n, 5'h1F);
    chk("req_ready", req_ready, 1'b0);
    @(posedge core_clk);
    rst <= 1'b0;
    // Second pass: low-active asynchronous ready, longer phases
    for (p = 0; p < 2; p++)
    begin
      @(posedge core_clk);
      ready_act_high <= (p == 0);
      ready_async <= (p == 1);
      addr_lines <= (p == 0) ? 5'h18 : 5'h14;
      seg_lines <= (p == 0) ? 3'h7 : 3'h3;
      for (k = 0; k < NCS; k++)
        cs_timing_config[k] <= '{2'(p), 4'h1, 2'(p)};
      foreach (rows[i])
        run_row(rows[i]);
      chk("aoe", aoe_seen, p ? 24'h070000 : 24'h7F0000);
    end
    // Shortest command on the ready window; async ready costs one period
    for (p = 0; p < 2; p++)
    begin
      @(posedge core_clk);
      ready_async <= (p == 1);
      for (k = 0; k < NCS; k++)
        cs_timing_config[k] <= '{2'h0, 4'h0, 2'h0};
      run_row(rows[3]);
      chk("rd_len", rd_len, REF_HALF_CYC * 2 * (p + 1));
    end
    @(posedge core_clk);
    ext_bus_en <= 1'b0;
    do_req('{24'h300000, 16'h0000, 1'b0, 1'b0}, s);
    chk("err_single", s.err, 1'b1);
    chk("cs_single", cs_seen, 5'h00);
    run_row(rows[5]);
    @(posedge core_clk);
    ext_bus_en <= 1'b1;
    arb_en <= 1'b1;
    hold_req_n_in <= 1'b0;
    repeat (6) @(negedge core_clk);
    chk("hold_ack", hold_acknowledge_n_out, 1'b0);
    chk("ctl_oe_held", ctl_oe, 1'b0);
    fork
      run_row(rows[0]);
      begin
        repeat (8) @(negedge core_clk);
        chk("bus_req_held", bus_request_out_n, 1'b0);
        chk("cs_held", cs_seen, 5'h00);
        @(posedge core_clk);
        hold_req_n_in <= 1'b1;
      end
    join
    @(posedge core_clk);
    slave_mode <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk("ack_oe_slave", hold_acknowledge_oe, 1'b0);
    chk("ctl_oe_slave", ctl_oe, 1'b0);
    fork
      run_row(rows[4]);
      begin
        repeat (8) @(negedge core_clk);
        chk("bus_req_slave", bus_request_out_n, 1'b0);
        @(posedge core_clk);
        hold_acknowledge_n_in <= 1'b0;
      end
    join
    @(posedge core_clk);
    arb_en <= 1'b0;
    slave_mode <= 1'b0;
    hold_acknowledge_n_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule // ebu_top_tb
